// ===== hw/viu_defs.svh
`ifndef VIU_DEFS_SVH
`define VIU_DEFS_SVH
`define VIU_PAGE_ONE_BASE 13'h0080
`define VIU_VEC_EXT 13'h0000
`define VIU_VEC_T1 13'h0004
`define VIU_VEC_T2 13'h0006
`define VIU_VEC_T3 13'h0008
`define VIU_REG_A_RESET 4'h0
`define VIU_REG_B_RESET 4'h0
`define VIU_EXT_EN_POS 0
`define VIU_T1_EN_POS 2
`define VIU_T2_EN_POS 3
`define VIU_T3_EN_POS 0
`define VIU_LAT_SHORT 2
`define VIU_LAT_LONG 3
`endif

// ===== hw/viu_pkg.sv
package viu_pkg;
   typedef logic [12:0] viu_addr_t;
   typedef logic [3:0] viu_nib_t;
   // Context held across one interrupt: pointer, carry, skip, A, B
   typedef logic [17:0] viu_ctx_t;
   typedef enum logic [3:0]
   {
      VIU_IDLE = 4'h1,
      VIU_WAIT = 4'h2,
      VIU_ENTER = 4'h4,
      VIU_SERVE = 4'h8
   } viu_state_t;
endpackage

// ===== hw/viu_context_save.sv
`timescale 1ns/10ps
`include "viu_defs.svh"
module viu_context_save
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic save,
   input wire viu_pkg::viu_ctx_t ctx_in,
   output viu_pkg::viu_ctx_t ctx_out
);
   import viu_pkg::*;
   viu_ctx_t held;
   viu_ctx_t next_held;

   // Single-level copy taken on entry
   always_comb
   begin
      next_held = held;
      if (save)
         next_held = ctx_in;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         held <= '0;
      else
         held <= next_held;
   end

   assign ctx_out = held;
endmodule

// ===== hw/viu_core.sv
`timescale 1ns/10ps
`include "viu_defs.svh"
module viu_core
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cycle_end,
   input wire logic instr_end,
   input wire logic multi_cycle,
   input wire logic enable_irq_instr,
   input wire logic disable_irq_instr,
   input wire logic irq_return_instr,
   input wire logic ext_edge,
   input wire logic [2:0] timer_underflow,
   input wire logic ext_edge_skip_test,
   input wire logic timer_one_skip_test,
   input wire logic timer_two_skip_test,
   input wire logic timer_three_skip_test,
   input wire logic reg_a_write,
   input wire logic reg_b_write,
   input wire viu_pkg::viu_nib_t reg_wdata,
   input wire viu_pkg::viu_addr_t return_addr,
   input wire viu_pkg::viu_ctx_t cpu_ctx,
   output viu_pkg::viu_nib_t irq_control_reg_a,
   output viu_pkg::viu_nib_t irq_control_reg_b,
   output logic global_irq_enable,
   output logic [3:0] request_flags,
   output logic skip_taken,
   output logic irq_take,
   output viu_pkg::viu_addr_t pc_load_value,
   output logic return_push,
   output viu_pkg::viu_addr_t return_stack_entry,
   output logic restore,
   output viu_pkg::viu_ctx_t restore_ctx
);
   import viu_pkg::*;

   logic rst_meta;
   logic rst_n;
   viu_state_t state;
   viu_state_t next_state;
   logic [3:0] flags;
   logic [3:0] next_flags;
   logic [3:0] enables;
   logic [3:0] pending;
   logic [3:0] grant;
   logic [3:0] served;
   logic [3:0] next_served;
   logic [3:0] skip_req;
   logic [3:0] skip_hit;
   logic [3:0] set_ev;
   logic [1:0] wait_cnt;
   logic [1:0] next_wait_cnt;
   logic ie;
   logic next_ie;
   logic enable_arm;
   logic next_enable_arm;
   viu_nib_t reg_a;
   viu_nib_t next_reg_a;
   viu_nib_t reg_b;
   viu_nib_t next_reg_b;
   viu_addr_t vec;
   viu_addr_t next_vec;
   viu_addr_t ret;
   viu_addr_t next_ret;
   logic skip_q;
   logic next_skip_q;

   // Reset release through two flops
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Enable bits gathered from two control registers
   assign enables = {reg_b[`VIU_T3_EN_POS], reg_a[`VIU_T2_EN_POS],
                     reg_a[`VIU_T1_EN_POS], reg_a[`VIU_EXT_EN_POS]};
   assign set_ev = {timer_underflow, ext_edge};
   assign skip_req = {timer_three_skip_test, timer_two_skip_test,
                      timer_one_skip_test, ext_edge_skip_test};
   assign pending = flags & enables & {4{ie}};

   // Skip tests only valid for disabled sources with flag set
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_skip
         assign skip_hit[gi] = skip_req[gi] & ~enables[gi] & flags[gi];
      end
   endgenerate

   // Fixed priority pick, lowest index wins
   always_comb
   begin
      grant = 4'h0;
      if (pending[0])
         grant = 4'h1;
      else if (pending[1])
         grant = 4'h2;
      else if (pending[2])
         grant = 4'h4;
      else if (pending[3])
         grant = 4'h8;
   end

   // Request flags: set wins over clear
   always_comb
   begin
      next_flags = flags;
      if (state == VIU_ENTER)
         next_flags = next_flags & ~served;
      next_flags = next_flags & ~skip_hit;
      next_flags = next_flags | set_ev;
   end

   // Global enable with one-instruction delay on enable
   always_comb
   begin
      next_ie = ie;
      next_enable_arm = enable_arm;
      if (instr_end && enable_arm)
      begin
         next_ie = 1'b1;
         next_enable_arm = 1'b0;
      end
      if (enable_irq_instr)
         next_enable_arm = 1'b1;
      if (disable_irq_instr)
      begin
         next_ie = 1'b0;
         next_enable_arm = 1'b0;
      end
      // Entry drops a stale arm so only a fresh enable reopens
      if (state == VIU_ENTER)
      begin
         next_ie = 1'b0;
         next_enable_arm = 1'b0;
      end
   end

   // Control registers written from the accumulator
   always_comb
   begin
      next_reg_a = reg_a;
      next_reg_b = reg_b;
      if (reg_a_write)
         next_reg_a = reg_wdata;
      if (reg_b_write)
         next_reg_b = reg_wdata;
   end

   // Entry sequencer counting machine cycles
   always_comb
   begin
      next_state = state;
      next_wait_cnt = wait_cnt;
      next_served = served;
      next_vec = vec;
      next_ret = ret;
      next_skip_q = 1'b0;
      case (state)
         VIU_IDLE:
            if (cycle_end && |pending)
            begin
               next_state = VIU_WAIT;
               next_served = grant;
               next_wait_cnt = multi_cycle ? 2'(`VIU_LAT_LONG - 1) : 2'(`VIU_LAT_SHORT - 1);
            end
         VIU_WAIT:
            if (cycle_end)
            begin
               if (wait_cnt == 2'h1)
               begin
                  next_state = VIU_ENTER;
                  next_ret = return_addr;
                  case (served)
                     4'h1: next_vec = `VIU_PAGE_ONE_BASE + `VIU_VEC_EXT;
                     4'h2: next_vec = `VIU_PAGE_ONE_BASE + `VIU_VEC_T1;
                     4'h4: next_vec = `VIU_PAGE_ONE_BASE + `VIU_VEC_T2;
                     default: next_vec = `VIU_PAGE_ONE_BASE + `VIU_VEC_T3;
                  endcase
               end
               next_wait_cnt = wait_cnt - 2'h1;
            end
         VIU_ENTER:
            next_state = VIU_SERVE;
         VIU_SERVE:
            next_state = VIU_IDLE;
         default:
            next_state = VIU_IDLE;
      endcase
      if (|skip_hit)
         next_skip_q = 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= VIU_IDLE;
         flags <= 4'h0;
         ie <= 1'b0;
         enable_arm <= 1'b0;
         reg_a <= `VIU_REG_A_RESET;
         reg_b <= `VIU_REG_B_RESET;
         served <= 4'h0;
         wait_cnt <= 2'h0;
         vec <= 13'h0000;
         ret <= 13'h0000;
         skip_q <= 1'b0;
      end
      else
      begin
         state <= next_state;
         flags <= next_flags;
         ie <= next_ie;
         enable_arm <= next_enable_arm;
         reg_a <= next_reg_a;
         reg_b <= next_reg_b;
         served <= next_served;
         wait_cnt <= next_wait_cnt;
         vec <= next_vec;
         ret <= next_ret;
         skip_q <= next_skip_q;
      end
   end

   // Context store and restore
   viu_context_save u_ctx
   (
      .clk(clk),
      .rst_n(rst_n),
      .save(state == VIU_ENTER),
      .ctx_in(cpu_ctx),
      .ctx_out(restore_ctx)
   );

   // Entry outputs: vector load and return push
   assign irq_take = (state == VIU_ENTER);
   assign return_push = (state == VIU_ENTER);
   assign pc_load_value = vec;
   assign return_stack_entry = ret;
   assign restore = irq_return_instr;
   assign skip_taken = skip_q;
   assign irq_control_reg_a = reg_a;
   assign irq_control_reg_b = reg_b;
   assign global_irq_enable = ie;
   assign request_flags = flags;

   a_global_clear: assert property (@(posedge clk) disable iff (!rst_n)
      irq_take |=> !global_irq_enable) else $error("enable not cleared on entry");
   a_served_clear: assert property (@(posedge clk) disable iff (!rst_n)
      irq_take && !(|(served & set_ev)) |=> !(|(request_flags & served)))
      else $error("served flag kept");
   a_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
      ext_edge |=> request_flags[0]) else $error("edge flag not set");
   a_vector_range: assert property (@(posedge clk) disable iff (!rst_n)
      irq_take |-> pc_load_value >= 13'h0080 && pc_load_value <= 13'h00FF)
      else $error("vector out of page");
   a_take_gated: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state == VIU_WAIT) |-> $past(ie)) else $error("entry while disabled");
   a_enable_delay: assert property (@(posedge clk) disable iff (!rst_n)
      enable_irq_instr && !global_irq_enable && !instr_end |=> !global_irq_enable)
      else $error("enable too early");
   a_disable_instr: assert property (@(posedge clk) disable iff (!rst_n)
      disable_irq_instr |=> !global_irq_enable) else $error("disable ignored");
   a_skip_clear: assert property (@(posedge clk) disable iff (!rst_n)
      skip_hit[1] && !set_ev[1] |=> !request_flags[1]) else $error("skip kept flag");
endmodule

// ===== dv/viu_seq_model.sv
`timescale 1ns/10ps
module viu_seq_model
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic multi_cycle,
   output logic cycle_end,
   output logic instr_end
);
   logic [1:0] phase;
   logic odd;
   // Four-clock machine cycle; odd marks the second half of a two-cycle op
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         phase <= 2'h0;
         odd <= 1'b0;
      end
      else
      begin
         phase <= phase + 2'h1;
         if (phase == 2'h3)
            odd <= multi_cycle ? !odd : 1'b0;
      end
   end
   // Instruction ends every cycle, or every second one when multi-cycle
   assign cycle_end = (phase == 2'h3);
   assign instr_end = cycle_end && (!multi_cycle || odd);
endmodule

// ===== dv/testbench.sv
`timescale 1ns/10ps
`include "viu_defs.svh"
module testbench;
   import viu_pkg::*;
   logic clk = 0, arst_n = 0, multi_cycle = 0, cycle_end, instr_end;
   logic en_i = 0, dis_i = 0, ret_i = 0, ext_edge = 0, wa = 0, wb = 0;
   logic skt0 = 0, skt1 = 0, skt2 = 0, skt3 = 0;
   logic [2:0] tmr = 3'h0;
   viu_nib_t wdata = 4'h0, reg_a, reg_b;
   viu_addr_t ret_addr = 13'h0000, pc_val, stack_val;
   viu_ctx_t ctx = 18'h00000, rctx;
   logic ie, skip_taken, irq_take, push, restore;
   logic [3:0] flags;
   int errors = 0, checks_done = 0, takes = 0;
   always #2 clk = !clk;
   // Count entries mid-cycle, away from the edge that launches them
   always @(negedge clk) if (irq_take === 1'b1) takes++;
   viu_seq_model seq (.clk(clk), .arst_n(arst_n), .multi_cycle(multi_cycle),
      .cycle_end(cycle_end), .instr_end(instr_end));
   viu_core dut (.clk(clk), .arst_n(arst_n), .cycle_end(cycle_end), .instr_end(instr_end),
      .multi_cycle(multi_cycle), .enable_irq_instr(en_i), .disable_irq_instr(dis_i),
      .irq_return_instr(ret_i), .ext_edge(ext_edge), .timer_underflow(tmr),
      .ext_edge_skip_test(skt0), .timer_one_skip_test(skt1), .timer_two_skip_test(skt2),
      .timer_three_skip_test(skt3), .reg_a_write(wa), .reg_b_write(wb), .reg_wdata(wdata),
      .return_addr(ret_addr), .cpu_ctx(ctx), .irq_control_reg_a(reg_a), .irq_control_reg_b(reg_b),
      .global_irq_enable(ie), .request_flags(flags), .skip_taken(skip_taken), .irq_take(irq_take),
      .pc_load_value(pc_val), .return_push(push), .return_stack_entry(stack_val),
      .restore(restore), .restore_ctx(rctx));
   // Compare and count
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic b, input viu_nib_t d);
      wa = !b;
      wb = b;
      wdata = d;
      tick();
      wa = 0;
      wb = 0;
   endtask
   task automatic raise_all();
      ext_edge = 1;
      tmr = 3'h7;
      tick();
      ext_edge = 0;
      tmr = 3'h0;
      tick(2);
   endtask
   // Global enable arms one instruction late and drops on disable
   task automatic test_enable();
      while (instr_end !== 1'b1) tick();
      en_i = 1;
      tick();
      en_i = 0;
      check(ie, 0);
      tick(4);
      check(ie, 1);
      dis_i = 1;
      tick();
      dis_i = 0;
      tick(2);
      check(ie, 0);
      $display("test enable done");
   endtask
   // Flags latch while blocked; skip test works only on disabled sources
   task automatic test_skip();
      raise_all();
      check(flags, 4'hF);
      en_i = 1;
      tick();
      en_i = 0;
      tick(20);
      check(takes, 0);
      skt1 = 1;
      tick();
      skt1 = 0;
      check(skip_taken, 1);
      tick();
      check(flags, 4'hD);
      dis_i = 1;
      wr(0, 4'h8);
      dis_i = 0;
      check(reg_a, 4'h8);
      skt2 = 1;
      tick();
      skt2 = 0;
      check(skip_taken, 0);
      tick();
      check(flags, 4'hD);
      $display("test skip done");
   endtask
   // Pending sources served in priority order with vector, push and context
   task automatic test_priority();
      logic [12:0] vec [4];
      logic [3:0] exp;
      int n, w;
      vec = '{13'h0080, 13'h0084, 13'h0086, 13'h0088};
      exp = 4'hF;
      wr(0, 4'hD);
      wr(1, 4'h1);
      check(reg_b, 4'h1);
      raise_all();
      for (int i = 0; i < 4; i++)
      begin
         ctx = 18'h2A5C0 + 18'(i);
         ret_addr = 13'h0140 + 13'(i);
         en_i = 1;
         tick();
         en_i = 0;
         n = 0;
         w = 0;
         while (irq_take !== 1'b1 && w < 60)
         begin
            tick();
            w++;
            if (ie === 1'b1 && cycle_end === 1'b1) n++;
         end
         check(w < 60, 1);
         check(push, 1);
         check(n, `VIU_LAT_SHORT);
         tick(2);
         ctx = 18'h00000;
         exp[i] = 1'b0;
         check(pc_val, vec[i]);
         check(stack_val, 13'h0140 + 13'(i));
         check(flags, exp);
         check(ie, 0);
         ret_i = 1;
         #1;
         check(restore, 1);
         check(rctx, 18'h2A5C0 + 18'(i));
         tick();
         ret_i = 0;
      end
      check(takes, 4);
      $display("test priority done");
   endtask
   // Multi-cycle instruction stretches entry to the long latency
   task automatic test_multi();
      int n;
      int w;
      n = 0;
      w = 0;
      multi_cycle = 1;
      ext_edge = 1;
      en_i = 1;
      tick();
      ext_edge = 0;
      en_i = 0;
      while (irq_take !== 1'b1 && w < 100)
      begin
         tick();
         w++;
         if (ie === 1'b1 && cycle_end === 1'b1) n++;
      end
      check(w < 100, 1);
      check(n, `VIU_LAT_LONG);
      check(pc_val, 13'h0080);
      tick(2);
      multi_cycle = 0;
      check(takes, 5);
      $display("test multi done");
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      #1;
      arst_n = 1;
      tick(4);
      test_enable();
      test_skip();
      test_priority();
      test_multi();
      report_and_stop();
   end
   // Watchdog well beyond the expected run
   initial
   begin
      #20000;
      errors++;
      report_and_stop();
   end
endmodule
